// ===== verilog/seeprm_pkg.sv
// shared constants and types of the serial eeprom command engine
package seeprm_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ    = 250;   // core clock rate
	localparam int FILT_NS    = 50;    // narrowest pulse that passes
	// least time, rounded up to whole core cycles
	localparam int FILT_CYC   = (FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int WC_CYC_DEF = 2500;  // programming cycle, in clocks

	// ************************************************************
	// array and page layout
	// ************************************************************
	localparam int ADDR_W_DEF = 12;    // array address width
	localparam int OFS_W      = 5;     // width of the in-page offset
	localparam int PAGE_BYTES = 32;    // bytes latched per page
	localparam int TMR_W      = 32;    // programming timer width

	// ************************************************************
	// address word layout
	// ************************************************************
	localparam int TYPE_HI    = 7;     // type code, top bit
	localparam int TYPE_LO    = 4;     // type code, low bit
	localparam int SEL_HI     = 3;     // select code, top bit
	localparam int SEL_LO     = 1;     // select code, low bit
	localparam int DIR_BIT    = 0;     // direction bit position
	localparam logic       DIR_READ      = 1'b1;
	// arbitrary neutral type code, override per product
	localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
	localparam logic [3:0] BYTE_BITS     = 4'h8; // bits per word

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic LINE_IDLE = 1'b1; // released bus level
	localparam logic RST_OE_N  = 1'b1; // data pin released

	// protocol states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV  = 3'h1,
		ST_AHI  = 3'h2,
		ST_ALO  = 3'h3,
		ST_WDAT = 3'h4,
		ST_RDAT = 3'h5,
		ST_MACK = 3'h6,
		ST_WAIT = 3'h7
	} seeprm_st_e;

	// the two bus lines travel together
	typedef struct packed {
		logic scl;
		logic sda;
	} seeprm_bus_s;

endpackage

// ===== verilog/seeprm_glitch.sv
// synchroniser and pulse suppressor for one bus line
`timescale 1ns/1ps
module seeprm_glitch import seeprm_pkg::*; #(
	parameter int FILT = FILT_CYC
) (
	// core clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// line from the link domain and its filtered level
	input  wire logic din,
	output logic      dout
);

	localparam int CW = $clog2(FILT + 1);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic          meta;  // first synchroniser stage
		logic          sync;  // second synchroniser stage
		logic [CW-1:0] cnt;   // cycles the new level has held
		logic          lvl;   // accepted level
	} seeprm_flt_s;

	seeprm_flt_s r;   // registered state
	seeprm_flt_s n;   // next state

	// accept a new level only after it held for FILT cycles
	always_comb begin
		n      = r;
		n.meta = din;
		n.sync = r.meta;
		if (r.sync == r.lvl) begin
			// no change pending
			n.cnt = '0;
		end else if (r.cnt == CW'(FILT - 1)) begin
			// stable long enough
			n.lvl = r.sync;
			n.cnt = '0;
		end else begin
			n.cnt = r.cnt + CW'(1);
		end
	end

	// register the state, idle bus level under reset
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= '{meta: LINE_IDLE, sync: LINE_IDLE, cnt: '0,
				lvl: LINE_IDLE};
		end else begin
			r <= n;
		end
	end

	assign dout = r.lvl;

endmodule

// ===== verilog/seeprm_engine.sv
// two-wire serial eeprom target: page write, polling and reads
`timescale 1ns/1ps
module seeprm_engine import seeprm_pkg::*; #(
	parameter int         ADDR_W    = ADDR_W_DEF,
	parameter int         WC_CYC    = WC_CYC_DEF,
	// arbitrary neutral default for the device type code
	parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF
) (
	// core clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// link side sampling clock
	input  wire logic       link_clk,
	// bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n,
	// hard-wired select straps
	input  wire logic [2:0] chip_select_pins,
	// status
	output logic            prog_busy
);

	localparam int DEPTH = 1 << ADDR_W;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		seeprm_st_e        st;       // protocol state
		logic [3:0]        bitcnt;   // bits seen in current word
		logic              ackph;    // in the ninth clock
		logic [7:0]        sh;       // receive shifter
		logic [7:0]        tx;       // transmit shifter
		logic              mack;     // controller acknowledge bit
		logic [ADDR_W-1:0] cnt;      // internal address counter
		logic [7:0]        ahi;      // first memory address byte
		logic              wrote;    // data latched this frame
		logic              busy;     // programming cycle running
		logic [TMR_W-1:0]  tmr;      // programming countdown
		logic [PAGE_BYTES-1:0] mask; // latched page locations
		logic              oe_n;     // data pin enable, low drives
		logic              dout;     // data pin output level
		seeprm_bus_s       prev;     // filtered lines, last cycle
		logic [2:0]        sel_m;    // strap synchroniser stage 1
		logic [2:0]        sel;      // strap synchroniser stage 2
	} seeprm_eng_s;

	localparam seeprm_eng_s ENG_RST = '{
		st:     ST_IDLE,
		oe_n:   RST_OE_N,
		prev:   '{scl: LINE_IDLE, sda: LINE_IDLE},
		sel_m:  3'h0,
		sel:    3'h0,
		default: '0
	};

	seeprm_eng_s r;   // registered state
	seeprm_eng_s n;   // next state

	// ************************************************************
	// storage
	// ************************************************************
	logic [7:0] mem  [0:DEPTH-1];       // the array itself
	logic [7:0] pbuf [0:PAGE_BYTES-1];  // page latch

	logic             buf_we;   // write into page latch
	logic [OFS_W-1:0] buf_idx;  // latch location
	logic [7:0]       buf_dat;  // latch data
	logic             commit;   // copy latch into array
	logic [7:0]       rd_byte;  // byte at the address counter

	// ************************************************************
	// link domain front end
	// ************************************************************
	seeprm_bus_s lnk_m;   // first stage on the link clock
	seeprm_bus_s lnk_s;   // second stage on the link clock

	// pins pass two flops on the link clock
	always_ff @(posedge link_clk) begin
		lnk_m <= '{scl: scl_i, sda: sda_i};
		lnk_s <= lnk_m;
	end

	// ************************************************************
	// crossing and filtering into the core domain
	// ************************************************************
	seeprm_bus_s fb;   // filtered lines
	logic [1:0]  fb_v;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_flt
			// each line crosses by two flops, then short pulses drop
			seeprm_glitch #(
				.FILT (FILT_CYC)
			) u_flt (
				.clock (clock),
				.srst  (srst),
				.din   (lnk_s[gi]),
				.dout  (fb_v[gi])
			);
		end
	endgenerate

	assign fb = seeprm_bus_s'(fb_v);

	// ************************************************************
	// helpers
	// ************************************************************
	// load the byte at the counter, drive its msb, advance counter
	function automatic seeprm_eng_s load_tx(input seeprm_eng_s s,
		input logic [7:0] b);
		seeprm_eng_s t;
		t        = s;
		t.oe_n   = b[7];
		t.tx     = {b[6:0], 1'b0};
		t.cnt    = s.cnt + ADDR_W'(1);
		t.bitcnt = 4'h0;
		return t;
	endfunction

	// line events on the filtered bus
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic match;

	assign rise  = fb.scl & ~r.prev.scl;
	assign fall  = ~fb.scl & r.prev.scl;
	assign start = r.prev.scl & fb.scl & r.prev.sda & ~fb.sda;
	assign stop  = r.prev.scl & fb.scl & ~r.prev.sda & fb.sda;
	assign match = (r.sh[TYPE_HI:TYPE_LO] == TYPE_CODE) &&
		(r.sh[SEL_HI:SEL_LO] == r.sel);
	assign rd_byte = mem[r.cnt];

	// ************************************************************
	// protocol engine
	// ************************************************************
	always_comb begin
		n       = r;
		buf_we  = 1'b0;
		buf_idx = r.cnt[OFS_W-1:0];
		buf_dat = r.sh;
		commit  = 1'b0;
		n.prev  = fb;
		n.sel_m = chip_select_pins;
		n.sel   = r.sel_m;
		n.dout  = 1'b0;
		// programming countdown runs beside the bus logic
		if (r.busy) begin
			if (r.tmr == TMR_W'(1)) begin
				commit = 1'b1;
				n.busy = 1'b0;
				n.mask = '0;
			end else begin
				n.tmr = r.tmr - TMR_W'(1);
			end
		end
		if (start) begin
			// start or repeated start: unfinished data is dropped
			n.st     = ST_DEV;
			n.bitcnt = 4'h0;
			n.ackph  = 1'b0;
			n.oe_n   = 1'b1;
			n.wrote  = 1'b0;
		end else if (stop) begin
			// stop: release the bus and return to standby
			n.st    = ST_IDLE;
			n.oe_n  = 1'b1;
			n.ackph = 1'b0;
			n.wrote = 1'b0;
			if (r.wrote && !r.busy) begin
				n.busy = 1'b1;
				n.tmr  = TMR_W'(WC_CYC);
			end
		end else if (r.ackph) begin
			// ninth clock: hold the acknowledge until scl falls
			if (fall) begin
				n.ackph  = 1'b0;
				n.bitcnt = 4'h0;
				if (r.st == ST_RDAT) begin
					n = load_tx(n, rd_byte);
				end else begin
					n.oe_n = 1'b1;
				end
			end
		end else begin
			case (r.st)
				ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
					if (rise && (r.bitcnt != BYTE_BITS)) begin
						// shift in one bit, msb first
						n.sh     = {r.sh[6:0], fb.sda};
						n.bitcnt = r.bitcnt + 4'h1;
					end else if (fall && (r.bitcnt == BYTE_BITS)) begin
						// word complete: acknowledge by default
						n.oe_n  = 1'b0;
						n.ackph = 1'b1;
						case (r.st)
							ST_DEV: begin
								if (!match || r.busy) begin
									// other device, or still programming
									n.oe_n  = 1'b1;
									n.ackph = 1'b0;
									n.st    = ST_WAIT;
								end else if (r.sh[DIR_BIT] == DIR_READ) begin
									n.st = ST_RDAT;
								end else begin
									n.st = ST_AHI;
								end
							end
							ST_AHI: begin
								// first memory address byte
								n.ahi = r.sh;
								n.st  = ST_ALO;
							end
							ST_ALO: begin
								// second byte; bits beyond array dropped
								n.cnt  = ADDR_W'({r.ahi, r.sh});
								n.mask = '0;
								n.st   = ST_WDAT;
							end
							default: begin
								// data byte goes to the page latch
								buf_we = 1'b1;
								n.mask[r.cnt[OFS_W-1:0]] = 1'b1;
								n.cnt[OFS_W-1:0] = r.cnt[OFS_W-1:0] +
									OFS_W'(1);
								n.wrote = 1'b1;
							end
						endcase
					end
				end
				ST_RDAT: begin
					if (rise) begin
						// controller samples the bit on this edge
						n.bitcnt = r.bitcnt + 4'h1;
					end else if (fall) begin
						if (r.bitcnt == BYTE_BITS) begin
							// byte done, release for the acknowledge
							n.oe_n   = 1'b1;
							n.bitcnt = 4'h0;
							n.st     = ST_MACK;
						end else begin
							// next bit of the byte
							n.oe_n = r.tx[7];
							n.tx   = {r.tx[6:0], 1'b0};
						end
					end
				end
				ST_MACK: begin
					if (rise) begin
						// sample the controller acknowledge
						n.mack   = fb.sda;
						n.bitcnt = 4'h1;
					end else if (fall && (r.bitcnt == 4'h1)) begin
						if (!r.mack) begin
							// low acknowledge: next byte, wraps at end
							n    = load_tx(n, rd_byte);
							n.st = ST_RDAT;
						end else begin
							// no acknowledge: wait for the stop
							n.st = ST_WAIT;
						end
					end
				end
				default: begin
					// idle or not addressed: only start and stop matter
					n.oe_n = 1'b1;
				end
			endcase
		end
	end

	// register the engine state
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= ENG_RST;
		end else begin
			r <= n;
		end
	end

	// page latch and commit into the array
	always_ff @(posedge clock) begin
		if (buf_we) begin
			pbuf[buf_idx] <= buf_dat;
		end
		if (commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (r.mask[i]) begin
					mem[{r.cnt[ADDR_W-1:OFS_W], OFS_W'(i)}] <= pbuf[i];
				end
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign sda_o     = r.dout;
	assign sda_oe_n  = r.oe_n;
	assign prog_busy = r.busy;

endmodule

// ===== test/seeprm_chk.sv
// port checker for the serial eeprom engine
`timescale 1ns/1ps
module seeprm_chk import seeprm_pkg::*; #(
	parameter int WC_CYC = WC_CYC_DEF
) (
	// core clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// link clock
	input  wire logic       link_clk,
	// bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       sda_o,
	input  wire logic       sda_oe_n,
	// straps and status
	input  wire logic [2:0] chip_select_pins,
	input  wire logic       prog_busy
);
	// cycles spent in the running programming cycle
	logic [TMR_W-1:0] busy_cnt_r;
	logic [TMR_W-1:0] busy_cnt_nxt;
	// count while busy, clear otherwise
	always_comb begin
		busy_cnt_nxt = prog_busy ? busy_cnt_r + 1'b1 : '0;
	end
	always_ff @(posedge clock) begin
		busy_cnt_r <= srst ? '0 : busy_cnt_nxt;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	a_sda_zero: assert property (sda_o == 1'b0)
		else $error("data output not low");
	a_rst_idle: assert property ($fell(srst) |-> sda_oe_n && !prog_busy)
		else $error("not idle after reset");
	a_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_r == WC_CYC)
		else $error("programming time wrong");
	a_busy_max: assert property (busy_cnt_r <= WC_CYC)
		else $error("programming cycle too long");
	a_busy_hold: assert property ($rose(prog_busy) |-> prog_busy [*8])
		else $error("programming cycle cut short");
	a_busy_cause: assert property ($rose(prog_busy) |-> scl_i && sda_i)
		else $error("programming began before stop");
	a_busy_quiet: assert property (prog_busy |-> sda_oe_n)
		else $error("pin pulled while programming");
	a_drv_clk_low: assert property ($changed(sda_oe_n) |-> !scl_i)
		else $error("data changed with clock high");
endmodule
bind seeprm_engine seeprm_chk #(.WC_CYC(WC_CYC)) u_seeprm_chk (
	.clock(clock), .srst(srst), .link_clk(link_clk), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
	.chip_select_pins(chip_select_pins), .prog_busy(prog_busy));

// ===== test/seeprm_ctl.sv
// two-wire bus controller model for the eeprom pins
`timescale 1ns/1ps
module seeprm_ctl (
	// timing reference and resolved data wire
	input  wire logic link_clk,
	input  wire logic sda_w,
	// driven pins, high means released
	output logic      scl,
	output logic      sda,
	// one pulse per ack or data result
	output logic      res_stb,
	output logic [8:0] res
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		res_stb = 1'b0;
		res = '0;
	end
	// wait n link cycles, then step past the edge
	task automatic q(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	// one bit: data in low phase, sample mid high phase
	task automatic bit_io(input logic b, input logic g, output logic s);
		sda = b;
		if (g) begin
			// spike on the clock, narrower than the filter
			scl = 1'b1;
			#30 scl = 1'b0;
		end
		q(11);
		scl = 1'b1;
		q(3);
		s = sda_w;
		q(3);
		scl = 1'b0;
		q(2);
	endtask
	// hand a result to the bench
	task automatic post(input logic k, input logic [7:0] v);
		res = {k, v};
		res_stb = 1'b1;
		#1 res_stb = 1'b0;
	endtask
	// start or repeated start
	task automatic start();
		sda = 1'b1;
		q(4);
		scl = 1'b1;
		q(4);
		sda = 1'b0;
		q(4);
		scl = 1'b0;
		q(2);
	endtask
	task automatic stop();
		sda = 1'b0;
		q(4);
		scl = 1'b1;
		q(4);
		sda = 1'b1;
		q(8);
	endtask
	// byte out msb first, then release for the target's ack
	task automatic wbyte(input logic [7:0] b, input logic g);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], g && i == 4, s);
		bit_io(1'b1, 1'b0, s);
		post(1'b0, {7'h0, s});
	endtask
	// byte in, then our ack: low continues, high ends
	task automatic rbyte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, 1'b0, b[i]);
		post(1'b1, b);
		bit_io(ack, 1'b0, s);
	endtask
endmodule

// ===== test/test_seeprm_engine.sv
// self-checking bench for the serial eeprom engine
`timescale 1ns/1ps
module test_seeprm_engine import seeprm_pkg::*;;
	// clocks, reset, straps and pins
	logic       clock;
	logic       srst;
	logic       link_clk;
	logic [2:0] cs;
	logic       scl;
	logic       sda;
	wire        sda_w;
	logic       sda_o;
	logic       sda_oe_n;
	logic       prog_busy;
	logic       res_stb;
	logic [8:0] res;
	// expected results, oldest first
	logic [8:0] notes[$];
	logic [8:0] n;
	logic [7:0] d[4];
	logic [7:0] dw;
	logic [7:0] dr;
	int         seed;
	int         err_count;
	int         checked;
	// open drain wire with pull-up
	assign sda_w = sda & (sda_oe_n | sda_o);
	seeprm_engine #(.WC_CYC(6000)) u_seeprm_engine (
		.clock(clock), .srst(srst), .link_clk(link_clk), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.chip_select_pins(cs), .prog_busy(prog_busy));
	seeprm_ctl u_seeprm_ctl (.link_clk(link_clk), .sda_w(sda_w),
		.scl(scl), .sda(sda), .res_stb(res_stb), .res(res));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		link_clk = 1'b0;
		#13;
		forever #40 link_clk = ~link_clk;
	end
	task automatic finish_test();
		if (notes.size() != 0) err_count++;
		$display("errors %0d checked %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp_ack(input logic e, input logic s);
		checked++;
		if (s !== e) begin
			$display("BAD ack exp %0h seen %0h", e, s);
			err_count++;
		end
	endtask
	task automatic cmp_data(input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			$display("BAD data exp %0h seen %0h", e, s);
			err_count++;
		end
	endtask
	// note the expectation, then run the byte
	task automatic wr(input logic [7:0] b, input logic a, input logic g);
		notes.push_back({1'b0, 7'h0, a});
		u_seeprm_ctl.wbyte(b, g);
	endtask
	task automatic rd(input logic [7:0] v, input logic ack);
		logic [7:0] b;
		notes.push_back({1'b1, v});
		u_seeprm_ctl.rbyte(ack, b);
	endtask
	// dummy write loading the counter, then read start
	task automatic set_rd(input logic [7:0] hi, input logic [7:0] lo);
		u_seeprm_ctl.start();
		wr(dw, 1'b0, 1'b0);
		wr(hi, 1'b0, 1'b0);
		wr(lo, 1'b0, 1'b0);
		u_seeprm_ctl.start();
		wr(dr, 1'b0, 1'b0);
	endtask
	// result watcher takes the oldest note
	always @(posedge res_stb) begin
		n = notes.pop_front();
		if (n[8])
			cmp_data(n[7:0], res[7:0]);
		else
			cmp_ack(n[0], res[0]);
	end
	initial begin
		seed = 32'h1695;
		err_count = 0;
		checked = 0;
		srst = 1'b1;
		cs = 3'($random(seed));
		for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
		dw = {TYPE_CODE_DEF, cs, 1'b0};
		dr = {TYPE_CODE_DEF, cs, 1'b1};
		repeat (12) @(posedge clock);
		#1 srst = 1'b0;
		repeat (250) @(posedge clock);
		// foreign select code is refused
		u_seeprm_ctl.start();
		wr({TYPE_CODE_DEF, ~cs, 1'b0}, 1'b1, 1'b0);
		u_seeprm_ctl.stop();
		// four bytes from offset 30 wrap inside the page
		u_seeprm_ctl.start();
		wr(dw, 1'b0, 1'b0);
		wr(8'h00, 1'b0, 1'b0);
		wr(8'h1e, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) wr(d[i], 1'b0, i == 1);
		u_seeprm_ctl.stop();
		// poll while busy, then after the cycle
		u_seeprm_ctl.start();
		wr(dw, 1'b1, 1'b0);
		u_seeprm_ctl.stop();
		// look just after the edge, once the flag has settled
		for (int k = 0; k < 8000 && prog_busy !== 1'b0; k++) begin
			@(posedge clock);
			#1;
		end
		cmp_ack(1'b0, prog_busy);
		if (prog_busy !== 1'b0) finish_test();
		u_seeprm_ctl.start();
		wr(dw, 1'b0, 1'b0);
		u_seeprm_ctl.stop();
		// top bits above the array are ignored
		set_rd(8'hf0, 8'h00);
		rd(d[2], 1'b1);
		u_seeprm_ctl.stop();
		// current address follows the last read
		u_seeprm_ctl.start();
		wr(dr, 1'b0, 1'b0);
		rd(d[3], 1'b1);
		u_seeprm_ctl.stop();
		set_rd(8'h00, 8'h1e);
		rd(d[0], 1'b0);
		rd(d[1], 1'b1);
		u_seeprm_ctl.stop();
		finish_test();
	end
endmodule
